/* logic/pcc_completer.sv */
/*
 * programmed-I/O completer: takes single-dword requests from the endpoint
 * request stream, serves them from four storage regions and returns
 * completions through a buffer onto the completion stream.
 * assumes the endpoint core drives the request stream on clk_i and holds
 * first byte enables valid with the first beat of each request.
 */
// Notes on behaviour
// - four 2 KB regions, 8192 bytes total
// - single-dword mem32, mem64, io reads and writes
// - window identifier in descriptor bits 114..112
// - builds for 64, 128, 256 bit streams
// - pure target, never originates requests
// - memory and io writes store payload
// - every served read answered with data completion
// - memory write ends at store, no reply
// - read request fully received, then completion
// - completion carries requester id and tag back
// - io write gets successful completion without data
// - longer requests swallowed whole, no completion
// - 000 mem32, 001 mem64, 110 expansion rom
`timescale 1ns/1ps
`include "pcc_params.svh"
module pcc_completer #(
   parameter int DATA_W = 64
) (
   // clock, reset and freeze
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic ce_i,
   // request stream from the endpoint core
   input wire logic [DATA_W-1:0] cq_tdata_i,
   input wire logic [3:0] cq_first_be_i,
   input wire logic cq_tvalid_i,
   input wire logic cq_tlast_i,
   output logic cq_tready_o,
   // completion stream to the endpoint core
   output logic [DATA_W-1:0] cc_tdata_o,
   output logic [DATA_W/32-1:0] cc_tkeep_o,
   output logic cc_tvalid_o,
   output logic cc_tlast_o,
   input wire logic cc_tready_i
);
   import pcc_pkg::*;

   // ------------------------------------------------------------
   // sizing
   // ------------------------------------------------------------
   localparam int KW = DATA_W / 32;
   localparam int MAXB = `PCC_PKT_W / DATA_W;
   localparam int NB = (`PCC_CPL_W + DATA_W - 1) / DATA_W;
   localparam int PADW = NB * DATA_W;
   localparam int FW = `PCC_CPL_W + 1;

   if (DATA_W != 64 && DATA_W != 128 && DATA_W != 256) begin : g_chk
      $error("pcc_completer: stream width must be 64, 128 or 256");
   end
   if (4 * `PCC_REGION_BYTES != `PCC_TOTAL_BYTES) begin : g_chk_mem
      $error("pcc_completer: region sizes do not fill the target space");
   end

   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   // io requests always land in the io region; memory requests pick by window
   function automatic logic [2:0] region_of(input logic [3:0] typ, input logic [2:0] win);
      region_of = 3'h0;
      if (typ == PCC_IO_RD || typ == PCC_IO_WR) begin
         region_of = {1'b1, PCC_REG_IO};
      end else if (typ == PCC_MEM_RD || typ == PCC_MEM_WR) begin
         if (win == `PCC_WIN_MEM32) begin
            region_of = {1'b1, PCC_REG_MEM32};
         end else if (win == `PCC_WIN_MEM64) begin
            region_of = {1'b1, PCC_REG_MEM64};
         end else if (win == `PCC_WIN_EROM) begin
            region_of = {1'b1, PCC_REG_EROM};
         end
      end
   endfunction : region_of

   function automatic logic [1:0] lo_off(input logic [3:0] be);
      lo_off = 2'h0;
      for (int i = 3; i >= 0; i--) begin
         if (be[i]) begin
            lo_off = 2'(i);
         end
      end
   endfunction : lo_off

   function automatic logic [12:0] bcnt_of(input logic [3:0] be);
      int hi;
      hi = 0;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            hi = i;
         end
      end
      bcnt_of = (be == 4'h0) ? 13'h1 : 13'(hi - int'(lo_off(be)) + 1);
   endfunction : bcnt_of

   function automatic logic [KW-1:0] keep_of(input int beat, input int dwc);
      for (int i = 0; i < KW; i++) begin
         keep_of[i] = (beat * KW + i) < dwc;
      end
   endfunction : keep_of

   // ------------------------------------------------------------
   // receive side
   // ------------------------------------------------------------
   pcc_rx_state_t rx_state_reg, rx_state_next;
   logic [2:0] beat_reg, beat_next;
   logic [`PCC_PKT_W-1:0] pkt_reg, pkt_next, pkt_merge;
   logic [3:0] be_reg, be_next;
   logic rdy_reg, rdy_next;
   logic [31:0] rdat_reg, rdat_next;
   logic take, single, accept, is_write, is_io_wr, is_read;
   logic [3:0] req_type;
   logic [2:0] win_id, reg_sel;
   logic [10:0] dwcnt;
   logic mem_en;
   logic [`PCC_MEM_AW-1:0] mem_addr;
   logic [31:0] mem_rdata;
   logic [FW-1:0] fifo_in_data, fifo_out_data;
   logic fifo_in_valid, fifo_in_ready, fifo_out_valid, fifo_out_ready;

   assign take = cq_tvalid_i && rdy_reg;

   always_comb begin
      pkt_merge = pkt_reg;
      if (take && int'(beat_reg) < MAXB) begin
         pkt_merge[int'(beat_reg) * DATA_W +: DATA_W] = cq_tdata_i;
      end
   end

   assign req_type = pkt_merge[`PCC_CQ_TYPE_LO +: 4];
   assign win_id = pkt_merge[`PCC_CQ_WIN_LO +: 3];
   assign dwcnt = pkt_merge[`PCC_CQ_DWCNT_LO +: 11];
   assign reg_sel = region_of(req_type, win_id);
   assign single = (dwcnt == 11'h1);
   assign accept = reg_sel[2] && single;
   assign is_io_wr = (req_type == PCC_IO_WR);
   assign is_write = (req_type == PCC_MEM_WR) || is_io_wr;
   assign is_read = (req_type == PCC_MEM_RD) || (req_type == PCC_IO_RD);

   always_comb begin
      rx_state_next = rx_state_reg;
      beat_next = beat_reg;
      pkt_next = pkt_reg;
      be_next = be_reg;
      rdy_next = rdy_reg;
      rdat_next = rdat_reg;
      unique case (rx_state_reg)
         PCC_RX_RECV: begin
            // idle means open, so ready rises at the first clock edge after reset
            rdy_next = 1'b1;
            if (take) begin
               pkt_next = pkt_merge;
               if (beat_reg == 3'h0) begin
                  be_next = cq_first_be_i;
               end
               beat_next = (beat_reg == 3'h7) ? beat_reg : beat_reg + 3'h1;
               if (cq_tlast_i) begin
                  beat_next = 3'h0;
                  // unserved requests are swallowed here and stay silent
                  if (accept) begin
                     rx_state_next = PCC_RX_MEM;
                     rdy_next = 1'b0;
                  end
               end
            end
         end
         PCC_RX_MEM: begin
            if (is_io_wr) begin
               rx_state_next = PCC_RX_PUSH;
            end else if (is_write) begin
               rx_state_next = PCC_RX_RECV;
               rdy_next = 1'b1;
            end else begin
               rx_state_next = PCC_RX_RDAT;
            end
         end
         PCC_RX_RDAT: begin
            rdat_next = mem_rdata;
            rx_state_next = PCC_RX_PUSH;
         end
         PCC_RX_PUSH: begin
            // a full buffer holds us here, so the request stream stalls
            if (fifo_in_ready) begin
               rx_state_next = PCC_RX_RECV;
               rdy_next = 1'b1;
            end
         end
      endcase
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rx_state_reg <= PCC_RX_RECV;
         beat_reg <= 3'h0;
         pkt_reg <= '0;
         be_reg <= 4'h0;
         rdy_reg <= 1'b0;
         rdat_reg <= 32'h0;
      end else if (ce_i) begin
         rx_state_reg <= rx_state_next;
         beat_reg <= beat_next;
         pkt_reg <= pkt_next;
         be_reg <= be_next;
         rdy_reg <= rdy_next;
         rdat_reg <= rdat_next;
      end
   end

   assign cq_tready_o = rdy_reg;

   // ------------------------------------------------------------
   // storage access
   // ------------------------------------------------------------
   // wider windows wrap onto the 2 KB region
   assign mem_en = (rx_state_reg == PCC_RX_MEM);
   assign mem_addr = {reg_sel[1:0], pkt_reg[`PCC_CQ_ADDR_LO +: `PCC_REGION_AW]};

   pcc_mem #(
      .ADDR_W(`PCC_MEM_AW)
   ) u_mem (
      .clk_i(clk_i),
      .rst_n_i(rst_n_i),
      .ce_i(ce_i),
      .en_i(mem_en),
      .we_i(is_write),
      .addr_i(mem_addr),
      .be_i(be_reg),
      .wdata_i(pkt_reg[`PCC_CQ_DATA_LO +: 32]),
      .rdata_o(mem_rdata)
   );

   // ------------------------------------------------------------
   // completion build, only answers to received requests exist
   // ------------------------------------------------------------
   always_comb begin
      fifo_in_data = '0;
      fifo_in_data[`PCC_CPL_W] = !is_io_wr;
      fifo_in_data[`PCC_CC_LADDR_LO +: 7] = is_io_wr ? 7'h0 :
         {pkt_reg[`PCC_CQ_ADDR_LO +: 5], lo_off(be_reg)};
      fifo_in_data[`PCC_CC_BCNT_LO +: 13] = is_io_wr ? 13'h4 : bcnt_of(be_reg);
      fifo_in_data[`PCC_CC_DWCNT_LO +: 11] = is_io_wr ? 11'h0 : 11'h1;
      fifo_in_data[`PCC_CC_STAT_LO +: 3] = `PCC_STAT_OK;
      fifo_in_data[`PCC_CC_RID_LO +: 16] = pkt_reg[`PCC_CQ_RID_LO +: 16];
      fifo_in_data[`PCC_CC_TAG_LO +: 8] = pkt_reg[`PCC_CQ_TAG_LO +: 8];
      fifo_in_data[`PCC_CC_TC_LO +: 3] = pkt_reg[`PCC_CQ_TC_LO +: 3];
      fifo_in_data[`PCC_CC_ATTR_LO +: 3] = pkt_reg[`PCC_CQ_ATTR_LO +: 3];
      fifo_in_data[`PCC_CC_DATA_LO +: 32] = rdat_reg;
   end

   assign fifo_in_valid = (rx_state_reg == PCC_RX_PUSH);

   pcc_fifo #(
      .WIDTH(FW),
      .DEPTH(`PCC_FIFO_DEPTH)
   ) u_fifo (
      .clk_i(clk_i),
      .rst_n_i(rst_n_i),
      .ce_i(ce_i),
      .in_data_i(fifo_in_data),
      .in_valid_i(fifo_in_valid),
      .in_ready_o(fifo_in_ready),
      .out_data_o(fifo_out_data),
      .out_valid_o(fifo_out_valid),
      .out_ready_i(fifo_out_ready)
   );

   // ------------------------------------------------------------
   // completion stream serialiser
   // ------------------------------------------------------------
   logic [PADW-1:0] tx_word_reg, tx_word_next, w;
   logic [2:0] tx_dw_reg, tx_dw_next, d;
   logic [1:0] tx_beat_reg, tx_beat_next, b;
   logic tx_more_reg, tx_more_next, go, slot_free, last;
   logic [DATA_W-1:0] cc_data_reg, cc_data_next;
   logic [KW-1:0] cc_keep_reg, cc_keep_next;
   logic cc_valid_reg, cc_valid_next, cc_last_reg, cc_last_next;

   assign slot_free = !cc_valid_reg || cc_tready_i;
   assign fifo_out_ready = slot_free && !tx_more_reg;

   always_comb begin
      w = tx_word_reg;
      b = tx_beat_reg;
      d = tx_dw_reg;
      go = tx_more_reg;
      last = 1'b0;
      tx_word_next = tx_word_reg;
      tx_dw_next = tx_dw_reg;
      tx_beat_next = tx_beat_reg;
      tx_more_next = tx_more_reg;
      cc_data_next = cc_data_reg;
      cc_keep_next = cc_keep_reg;
      cc_valid_next = cc_valid_reg;
      cc_last_next = cc_last_reg;
      if (!tx_more_reg) begin
         w = PADW'(fifo_out_data[`PCC_CPL_W-1:0]);
         b = 2'h0;
         d = fifo_out_data[`PCC_CPL_W] ? 3'(`PCC_CC_DW_DATA) : 3'(`PCC_CC_DW_NODATA);
         go = fifo_out_valid;
      end
      if (slot_free) begin
         cc_valid_next = go;
         if (go) begin
            last = (int'(b) + 1) * KW >= int'(d);
            cc_data_next = w[int'(b) * DATA_W +: DATA_W];
            cc_keep_next = keep_of(int'(b), int'(d));
            cc_last_next = last;
            tx_more_next = !last;
            tx_beat_next = b + 2'h1;
            tx_word_next = w;
            tx_dw_next = d;
         end
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         tx_word_reg <= '0;
         tx_dw_reg <= 3'h0;
         tx_beat_reg <= 2'h0;
         tx_more_reg <= 1'b0;
         cc_data_reg <= '0;
         cc_keep_reg <= '0;
         cc_valid_reg <= 1'b0;
         cc_last_reg <= 1'b0;
      end else if (ce_i) begin
         tx_word_reg <= tx_word_next;
         tx_dw_reg <= tx_dw_next;
         tx_beat_reg <= tx_beat_next;
         tx_more_reg <= tx_more_next;
         cc_data_reg <= cc_data_next;
         cc_keep_reg <= cc_keep_next;
         cc_valid_reg <= cc_valid_next;
         cc_last_reg <= cc_last_next;
      end
   end

   assign cc_tdata_o = cc_data_reg;
   assign cc_tkeep_o = cc_keep_reg;
   assign cc_tvalid_o = cc_valid_reg;
   assign cc_tlast_o = cc_last_reg;

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_n_i || !ce_i);

   sequence rd_path_s;
      rx_state_reg == PCC_RX_RDAT ##1 rx_state_reg == PCC_RX_PUSH && fifo_in_data[`PCC_CPL_W];
   endsequence

   sequence io_ack_s;
      rx_state_reg == PCC_RX_PUSH && !fifo_in_data[`PCC_CPL_W]
         && fifo_in_data[`PCC_CC_STAT_LO +: 3] == `PCC_STAT_OK;
   endsequence

   drop_long_a : assert property (take && cq_tlast_i && !single |=>
      rx_state_reg == PCC_RX_RECV && cq_tready_o) else $error("long request not dropped");
   rd_answer_a : assert property (rx_state_reg == PCC_RX_MEM && is_read |=> rd_path_s)
      else $error("read not answered with data");
   mem_wr_quiet_a : assert property (mem_en && req_type == PCC_MEM_WR |=>
      rx_state_reg == PCC_RX_RECV && !fifo_in_valid) else $error("memory write replied");
   io_wr_ack_a : assert property (mem_en && is_io_wr |=> io_ack_s)
      else $error("io write lacks completion");
   win_mem64_a : assert property (mem_en && req_type == PCC_MEM_RD
      && win_id == `PCC_WIN_MEM64 |-> mem_addr[10:9] == PCC_REG_MEM64)
      else $error("wrong region for mem64 window");
   route_back_a : assert property (fifo_in_valid |->
      fifo_in_data[`PCC_CC_TAG_LO +: 8] == pkt_reg[`PCC_CQ_TAG_LO +: 8]
      && fifo_in_data[`PCC_CC_RID_LO +: 16] == pkt_reg[`PCC_CQ_RID_LO +: 16])
      else $error("completion lost requester identity");
   byte_mask_a : assert property (mem_en && is_write |-> be_reg == $past(be_next, 1))
      else $error("write byte enables changed");
   busy_stall_a : assert property (rx_state_reg != PCC_RX_RECV |-> !cq_tready_o)
      else $error("request taken while busy");
   cc_hold_a : assert property (cc_tvalid_o && !cc_tready_i |=>
      cc_tvalid_o && $stable(cc_tdata_o) && $stable(cc_tlast_o)) else $error("completion beat dropped");

endmodule : pcc_completer

/* logic/pcc_params.svh */
/*
 * constants of the programmed-I/O completer: request and completion descriptor
 * field positions, window identifier codes, storage sizes and buffer depth.
 * assumes the request descriptor is 128 bits with payload following it.
 */
`ifndef PCC_PARAMS_SVH
`define PCC_PARAMS_SVH

// ------------------------------------------------------------
// storage
// ------------------------------------------------------------
`define PCC_REGION_BYTES 2048
`define PCC_TOTAL_BYTES 8192
`define PCC_REGION_AW 9
`define PCC_MEM_AW 11

// ------------------------------------------------------------
// request descriptor fields
// ------------------------------------------------------------
`define PCC_PKT_W 256
`define PCC_CQ_ADDR_LO 2
`define PCC_CQ_DWCNT_LO 64
`define PCC_CQ_TYPE_LO 75
`define PCC_CQ_RID_LO 80
`define PCC_CQ_TAG_LO 96
`define PCC_CQ_WIN_LO 112
`define PCC_CQ_TC_LO 121
`define PCC_CQ_ATTR_LO 124
`define PCC_CQ_DATA_LO 128

// ------------------------------------------------------------
// matched window identifier codes
// ------------------------------------------------------------
`define PCC_WIN_MEM32 3'h0
`define PCC_WIN_MEM64 3'h1
`define PCC_WIN_EROM 3'h6

// ------------------------------------------------------------
// completion descriptor fields
// ------------------------------------------------------------
`define PCC_CPL_W 128
`define PCC_CC_LADDR_LO 0
`define PCC_CC_BCNT_LO 16
`define PCC_CC_DWCNT_LO 32
`define PCC_CC_STAT_LO 43
`define PCC_CC_RID_LO 48
`define PCC_CC_TAG_LO 64
`define PCC_CC_TC_LO 89
`define PCC_CC_ATTR_LO 92
`define PCC_CC_DATA_LO 96
`define PCC_CC_DW_NODATA 3
`define PCC_CC_DW_DATA 4
`define PCC_STAT_OK 3'h0

// ------------------------------------------------------------
// completion buffer
// ------------------------------------------------------------
`define PCC_FIFO_DEPTH 8

`endif

/* logic/pcc_pkg.sv */
/*
 * types of the programmed-I/O completer: request kinds, storage regions and
 * receive states. assumes the constants header is compiled alongside.
 */
package pcc_pkg;

   // ------------------------------------------------------------
   // request kinds and regions
   // ------------------------------------------------------------
   typedef enum logic [3:0] {
      PCC_MEM_RD = 4'h0,
      PCC_MEM_WR = 4'h1,
      PCC_IO_RD = 4'h2,
      PCC_IO_WR = 4'h3
   } pcc_req_t;

   typedef enum logic [1:0] {
      PCC_REG_IO = 2'h0,
      PCC_REG_MEM32 = 2'h1,
      PCC_REG_MEM64 = 2'h2,
      PCC_REG_EROM = 2'h3
   } pcc_region_t;

   // ------------------------------------------------------------
   // receive states, gray along recv, mem, rdat, push
   // ------------------------------------------------------------
   typedef enum logic [1:0] {
      PCC_RX_RECV = 2'b00,
      PCC_RX_MEM = 2'b01,
      PCC_RX_RDAT = 2'b11,
      PCC_RX_PUSH = 2'b10
   } pcc_rx_state_t;

endpackage : pcc_pkg

/* logic/pcc_fifo.sv */
/*
 * small synchronous fifo with valid and ready on both sides.
 * assumes one clock, an active-low asynchronous reset and a freeze enable.
 */
`timescale 1ns/1ps
module pcc_fifo #(
   parameter int WIDTH = 129,
   parameter int DEPTH = 8
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic ce_i,
   // filling side
   input wire logic [WIDTH-1:0] in_data_i,
   input wire logic in_valid_i,
   output logic in_ready_o,
   // draining side
   output logic [WIDTH-1:0] out_data_o,
   output logic out_valid_o,
   input wire logic out_ready_i
);
   localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

   if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin : g_chk
      $error("pcc_fifo: depth must be a power of two of at least 2");
   end

   logic [WIDTH-1:0] mem_reg [DEPTH];
   logic [PW-1:0] wr_reg, wr_next, rd_reg, rd_next;
   logic [PW:0] cnt_reg, cnt_next;
   logic push, pop;

   assign in_ready_o = (cnt_reg != (PW+1)'(DEPTH));
   assign out_valid_o = (cnt_reg != '0);
   assign out_data_o = mem_reg[rd_reg];
   assign push = in_valid_i && in_ready_o;
   assign pop = out_valid_o && out_ready_i;

   always_comb begin
      wr_next = push ? wr_reg + 1'b1 : wr_reg;
      rd_next = pop ? rd_reg + 1'b1 : rd_reg;
      cnt_next = cnt_reg + (PW+1)'(push) - (PW+1)'(pop);
   end

   always_ff @(posedge clk_i) begin
      if (ce_i && push) begin
         mem_reg[wr_reg] <= in_data_i;
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         wr_reg <= '0;
         rd_reg <= '0;
         cnt_reg <= '0;
      end else if (ce_i) begin
         wr_reg <= wr_next;
         rd_reg <= rd_next;
         cnt_reg <= cnt_next;
      end
   end

   fifo_bound_a : assert property (@(posedge clk_i) disable iff (!rst_n_i)
      cnt_reg <= (PW+1)'(DEPTH)) else $error("fifo count above depth");

endmodule : pcc_fifo

/* logic/pcc_mem.sv */
/*
 * word storage with byte-lane writes and a registered read port.
 * assumes one access per cycle, read data valid the cycle after enable.
 */
`timescale 1ns/1ps
module pcc_mem #(
   parameter int ADDR_W = 11
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic ce_i,
   // access port
   input wire logic en_i,
   input wire logic we_i,
   input wire logic [ADDR_W-1:0] addr_i,
   input wire logic [3:0] be_i,
   input wire logic [31:0] wdata_i,
   output logic [31:0] rdata_o
);
   if (ADDR_W < 1 || ADDR_W > 16) begin : g_chk
      $error("pcc_mem: address width out of range");
   end

   // storage has no reset: contents are undefined until written
   logic [31:0] mem_reg [2**ADDR_W];
   logic [31:0] rdata_reg;

   always_ff @(posedge clk_i) begin
      if (ce_i && en_i && we_i) begin
         for (int i = 0; i < 4; i++) begin
            if (be_i[i]) begin
               mem_reg[addr_i][8*i +: 8] <= wdata_i[8*i +: 8];
            end
         end
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rdata_reg <= 32'h0;
      end else if (ce_i && en_i && !we_i) begin
         rdata_reg <= mem_reg[addr_i];
      end
   end

   assign rdata_o = rdata_reg;

endmodule : pcc_mem

/* logic/pcc_fix_note.sv */
/*
 * holds no logic; the completer draws nothing from this file
 */

/* tb/pcc_core_model.sv */
/* core-side model of the request and completion streams of the completer.
   assumes DATA_W of 128: two request beats, one completion beat. */
`timescale 1ns/1ps
module pcc_core_model (
   // clock
   input wire logic clk_i,
   // request stream
   output logic [127:0] cq_tdata_o,
   output logic [3:0] cq_first_be_o,
   output logic cq_tvalid_o,
   output logic cq_tlast_o,
   input wire logic cq_tready_i,
   // completion stream
   input wire logic [127:0] cc_tdata_i,
   input wire logic [3:0] cc_tkeep_i,
   input wire logic cc_tvalid_i,
   input wire logic cc_tlast_i,
   output logic cc_tready_o
);
   initial begin
      cq_tdata_o = '0;
      cq_first_be_o = '0;
      cq_tvalid_o = 1'b0;
      cq_tlast_o = 1'b0;
      cc_tready_o = 1'b0;
   end
   // ------------------------------------------------------------
   // request packets
   // ------------------------------------------------------------
   function automatic logic [255:0] pkt(logic [3:0] ty, logic [2:0] w, logic [8:0] a,
      logic [10:0] cnt, logic [7:0] tg, logic [31:0] d);
      logic [255:0] p;
      p = '0;
      p[10:2] = a;
      p[74:64] = cnt;
      p[78:75] = ty;
      p[95:80] = 16'h1234;
      p[103:96] = tg;
      p[114:112] = w;
      p[159:128] = d;
      return p;
   endfunction : pkt
   // called just after an edge; each beat holds until ready is seen
   task automatic send(input logic [255:0] p, input logic [3:0] be, output bit ok);
      int n;
      ok = 1;
      for (int b = 0; b < 2; b++) begin
         cq_tdata_o <= p[b*128 +: 128];
         cq_first_be_o <= be;
         cq_tvalid_o <= 1'b1;
         cq_tlast_o <= (b == 1);
         n = 0;
         do begin
            @(posedge clk_i);
            n++;
         end while (!cq_tready_i && n < 200);
         if (cq_tready_i !== 1'b1) ok = 0;
      end
      cq_tvalid_o <= 1'b0;
      cq_tlast_o <= 1'b0;
      // released bus shows the inverse, not a stale copy
      cq_tdata_o <= ~p[255:128];
      // one idle edge, so a following request never re-raises valid in this step
      @(posedge clk_i);
   endtask : send
   // stall for st cycles, then wait at most lim cycles for one beat
   task automatic take(input int st, input int lim, output logic [132:0] r, output bit got);
      got = 0;
      r = '0;
      repeat (st) @(posedge clk_i);
      cc_tready_o <= 1'b1;
      for (int n = 0; n < lim && !got; n++) begin
         @(posedge clk_i);
         if (cc_tvalid_i === 1'b1 && cc_tready_o) begin
            got = 1;
            r = {cc_tlast_i, cc_tkeep_i, cc_tdata_i};
         end
      end
      cc_tready_o <= 1'b0;
   endtask : take
endmodule : pcc_core_model

/* tb/tb_pcc_completer.sv */
/* self-checking bench of the completer at DATA_W 128.
   assumes the core model file and the design files are compiled first. */
`timescale 1ns/1ps
`include "pcc_params.svh"
module tb_pcc_completer;
   import pcc_pkg::*;
   logic clk_i, rst_n_i, ce_i, cq_tvalid_i, cq_tlast_i, cq_tready_o;
   logic cc_tvalid_o, cc_tlast_o, cc_tready_i;
   logic [127:0] cq_tdata_i, cc_tdata_o;
   logic [3:0] cq_first_be_i, cc_tkeep_o;
   int miscompares = 0;
   int n_compared = 0;
   int cyc = 0;
   pcc_completer #(.DATA_W(128)) dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(ce_i),
      .cq_tdata_i(cq_tdata_i), .cq_first_be_i(cq_first_be_i), .cq_tvalid_i(cq_tvalid_i),
      .cq_tlast_i(cq_tlast_i), .cq_tready_o(cq_tready_o), .cc_tdata_o(cc_tdata_o),
      .cc_tkeep_o(cc_tkeep_o), .cc_tvalid_o(cc_tvalid_o), .cc_tlast_o(cc_tlast_o),
      .cc_tready_i(cc_tready_i));
   pcc_core_model peer (.clk_i(clk_i), .cq_tdata_o(cq_tdata_i), .cq_first_be_o(cq_first_be_i),
      .cq_tvalid_o(cq_tvalid_i), .cq_tlast_o(cq_tlast_i), .cq_tready_i(cq_tready_o),
      .cc_tdata_i(cc_tdata_o), .cc_tkeep_i(cc_tkeep_o), .cc_tvalid_i(cc_tvalid_o),
      .cc_tlast_i(cc_tlast_o), .cc_tready_o(cc_tready_i));
   // ------------------------------------------------------------
   // checking
   // ------------------------------------------------------------
   task automatic chk(input bit c, input string m);
      n_compared++;
      if (!c) begin
         miscompares++;
         $display("unexpected at %0t: %s", $time, m);
      end
   endtask : chk
   task automatic report_and_stop;
      $display("compared %0d, mismatched %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : report_and_stop
   task automatic wr(input logic [3:0] ty, input logic [2:0] w, input logic [8:0] a,
      input logic [31:0] d, input logic [3:0] be, input logic [10:0] cnt);
      bit ok;
      peer.send(peer.pkt(ty, w, a, cnt, 8'h0, d), be, ok);
      chk(ok, "write not taken");
   endtask : wr
   task automatic rd(input logic [3:0] ty, input logic [2:0] w, input logic [8:0] a,
      input logic [31:0] d, input int st);
      logic [132:0] r;
      bit ok, got;
      peer.send(peer.pkt(ty, w, a, 11'h1, a[7:0], 32'h0), 4'hf, ok);
      peer.take(st, 60, r, got);
      chk(ok && got, "read not answered");
      chk(r[127:96] === d, "read data");
      chk(r[45:43] === `PCC_STAT_OK && r[28:16] === 13'h4, "read header");
      chk(r[63:48] === 16'h1234 && r[71:64] === a[7:0], "routing fields");
      chk(r[132:128] === 5'h1f && r[6:0] === {a[4:0], 2'b00}, "read framing");
   endtask : rd
   task automatic none_out(input string m);
      logic [132:0] r;
      bit got;
      peer.take(0, 20, r, got);
      chk(!got, m);
   endtask : none_out
   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   task automatic t_regions;
      logic [2:0] wn[4] = '{3'h0, `PCC_WIN_MEM32, `PCC_WIN_MEM64, `PCC_WIN_EROM};
      logic [31:0] dv[4] = '{32'h0a0b0c0d, 32'h1b1c1d1e, 32'h2c2d2e2f, 32'h3d3e3f30};
      logic [132:0] r;
      bit got;
      for (int i = 0; i < 4; i++) begin
         wr(i == 0 ? PCC_IO_WR : PCC_MEM_WR, wn[i], 9'h5, dv[i], 4'hf, 11'h1);
         if (i == 0) begin
            peer.take(0, 60, r, got);
            chk(got && r[132:128] === 5'h17 && r[45:43] === `PCC_STAT_OK, "io ack");
            chk(r[28:16] === 13'h4 && r[127:96] === 32'h0, "io ack fields");
         end else none_out("write answered");
      end
      for (int i = 0; i < 4; i++) rd(i == 0 ? PCC_IO_RD : PCC_MEM_RD, wn[i], 9'h5, dv[i], 0);
      $display("test regions done");
   endtask : t_regions
   task automatic t_bytes;
      wr(PCC_MEM_WR, `PCC_WIN_MEM64, 9'h1ff, 32'h11223344, 4'hf, 11'h1);
      wr(PCC_MEM_WR, `PCC_WIN_MEM64, 9'h1ff, 32'haabbccdd, 4'h5, 11'h1);
      rd(PCC_MEM_RD, `PCC_WIN_MEM64, 9'h1ff, 32'h11bb33dd, 8);
      $display("test bytes done");
   endtask : t_bytes
   task automatic t_long;
      wr(PCC_MEM_WR, `PCC_WIN_MEM64, 9'h1ff, 32'h0, 4'hf, 11'h2);
      none_out("long write answered");
      wr(PCC_MEM_RD, `PCC_WIN_MEM64, 9'h1ff, 32'h0, 4'hf, 11'h2);
      none_out("long read answered");
      wr(PCC_MEM_RD, 3'h2, 9'h1ff, 32'h0, 4'hf, 11'h1);
      none_out("unmapped window answered");
      rd(PCC_MEM_RD, `PCC_WIN_MEM64, 9'h1ff, 32'h11bb33dd, 0);
      $display("test long done");
   endtask : t_long
   // ------------------------------------------------------------
   // clock, reset, run
   // ------------------------------------------------------------
   initial begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end
   // ceiling well above the roughly 250 cycles the tests need
   always @(posedge clk_i) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         miscompares++;
         report_and_stop();
      end
   end
   initial begin
      rst_n_i = 1'b0;
      ce_i = 1'b1;
      repeat (20) @(posedge clk_i);
      rst_n_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      t_regions();
      t_bytes();
      t_long();
      report_and_stop();
   end
endmodule : tb_pcc_completer
